//--- hw/arcop_pkg.sv
package arcop_pkg;

	// Register map of the operand bytes and the control/status register
	localparam logic [7:0] ARCOP_ADDR_BYTE0 = 8'hE9;
	localparam logic [7:0] ARCOP_ADDR_BYTE1 = 8'hEA;
	localparam logic [7:0] ARCOP_ADDR_BYTE2 = 8'hEB;
	localparam logic [7:0] ARCOP_ADDR_BYTE3 = 8'hEC;
	localparam logic [7:0] ARCOP_ADDR_BYTE4 = 8'hED;
	localparam logic [7:0] ARCOP_ADDR_BYTE5 = 8'hEE;
	localparam logic [7:0] ARCOP_ADDR_CTRL  = 8'hEF;

	// Index of each register relative to operand byte 0
	localparam logic [2:0] ARCOP_IDX_BYTE0 = 3'h0;
	localparam logic [2:0] ARCOP_IDX_BYTE1 = 3'h1;
	localparam logic [2:0] ARCOP_IDX_BYTE2 = 3'h2;
	localparam logic [2:0] ARCOP_IDX_BYTE3 = 3'h3;
	localparam logic [2:0] ARCOP_IDX_BYTE4 = 3'h4;
	localparam logic [2:0] ARCOP_IDX_BYTE5 = 3'h5;
	localparam logic [2:0] ARCOP_IDX_CTRL  = 3'h6;

	// Control/status field positions and reset values
	localparam int         ARCOP_ERR_BIT    = 7;
	localparam int         ARCOP_OVF_BIT    = 6;
	localparam int         ARCOP_DIR_BIT    = 5;
	localparam logic [7:0] ARCOP_CTRL_RESET = 8'h00;
	localparam logic [7:0] ARCOP_BYTE_RESET = 8'h00;

	// Execution times in clock cycles
	localparam logic [4:0] ARCOP_CYC_DIV32      = 5'h11;
	localparam logic [4:0] ARCOP_CYC_DIV16      = 5'h09;
	localparam logic [4:0] ARCOP_CYC_MUL        = 5'h0B;
	localparam logic [4:0] ARCOP_CYC_SHIFT_BASE = 5'h03;
	localparam logic [4:0] ARCOP_CYC_NORM_BASE  = 5'h04;

	// Largest product that does not overflow
	localparam logic [31:0] ARCOP_MUL_LIMIT = 32'h0000FFFF;

	typedef enum logic [2:0] {
		ARCOP_OP_NONE,
		ARCOP_OP_DIV32,
		ARCOP_OP_DIV16,
		ARCOP_OP_MUL,
		ARCOP_OP_SHIFT,
		ARCOP_OP_NORM
	} arcop_op_t;

	typedef enum logic [1:0] {
		ARCOP_PH_IDLE,
		ARCOP_PH_LOAD,
		ARCOP_PH_EXEC,
		ARCOP_PH_RESULT
	} arcop_phase_t;

	// One special function register access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} arcop_sfr_req_t;

	// Outcome of the arithmetic for the current operands
	typedef struct packed {
		logic [47:0] value;
		logic        ovf;
		logic [4:0]  count;
		logic [4:0]  cycles;
	} arcop_alu_res_t;

endpackage : arcop_pkg

//--- hw/arcop_alu.sv
module arcop_alu import arcop_pkg::*; (
	input  wire logic [47:0]    i_operands,
	input  wire arcop_op_t      i_op,
	input  wire logic           i_slr,
	input  wire logic [4:0]     i_sc,
	output arcop_alu_res_t      o_res
);

	logic [31:0] num32;
	logic [15:0] num16;
	logic [15:0] divisor;
	logic [31:0] product;
	logic [5:0]  lead;
	logic        found;
	logic [4:0]  steps;

	assign num32   = i_operands[31:0];
	assign num16   = i_operands[15:0];
	assign divisor = i_operands[47:32];
	assign product = num16 * divisor;

	// Leading zero count; an all-zero value is clamped to the widest count
	always_comb begin
		lead  = 6'h00;
		found = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (!found) begin
				if (num32[i]) begin
					found = 1'b1;
				end else begin
					lead = lead + 6'h01;
				end
			end
		end
		steps = (lead > 6'h1F) ? 5'h1F : lead[4:0];
	end

	// Untouched bytes pass through, so the commit can write the whole set
	always_comb begin
		o_res = '{value: i_operands, ovf: 1'b0, count: i_sc, cycles: ARCOP_CYC_DIV32};
		case (i_op)
			ARCOP_OP_DIV32: begin
				o_res.cycles = ARCOP_CYC_DIV32;
				o_res.ovf    = (divisor == 16'h0000);
				if (divisor != 16'h0000) begin
					o_res.value[31:0]  = num32 / {16'h0000, divisor};
					o_res.value[47:32] = 16'((num32 % {16'h0000, divisor}));
				end else begin
					o_res.value[31:0]  = 32'hFFFFFFFF;
					o_res.value[47:32] = num32[15:0];
				end
			end
			ARCOP_OP_DIV16: begin
				o_res.cycles = ARCOP_CYC_DIV16;
				o_res.ovf    = (divisor == 16'h0000);
				if (divisor != 16'h0000) begin
					o_res.value[15:0]  = num16 / divisor;
					o_res.value[47:32] = num16 % divisor;
				end else begin
					o_res.value[15:0]  = 16'hFFFF;
					o_res.value[47:32] = num16;
				end
			end
			ARCOP_OP_MUL: begin
				o_res.cycles      = ARCOP_CYC_MUL;
				o_res.ovf         = (product > ARCOP_MUL_LIMIT);
				o_res.value[31:0] = product;
			end
			ARCOP_OP_SHIFT: begin
				o_res.cycles      = ARCOP_CYC_SHIFT_BASE + ((i_sc - 5'h01) >> 1);
				o_res.value[31:0] = i_slr ? (num32 >> i_sc) : (num32 << i_sc);
			end
			ARCOP_OP_NORM: begin
				o_res.ovf         = num32[31];
				o_res.count       = steps;
				o_res.cycles      = (steps == 5'h00) ? ARCOP_CYC_NORM_BASE :
					ARCOP_CYC_NORM_BASE + ((steps - 5'h01) >> 1);
				o_res.value[31:0] = num32 << steps;
			end
			default: begin
				o_res.cycles = ARCOP_CYC_DIV32;
			end
		endcase
	end

endmodule : arcop_alu

//--- hw/arcop_top.sv
// What this block does
// - Unsigned arithmetic; results overwrite the operand bytes.
// - Writing operand byte 0 opens a sequence.
// - Byte 2 or 3 written selects 32/16 division.
// - Byte 4 selects 16/16 division; byte 1 multiplication.
// - Final write to byte 5 or control starts.
// - Zero shift count normalizes, otherwise shifts.
// - Direction bit: zero left, one right.
// - Shift the 32-bit value, zeros fill in.
// - Normalize until top bit set; count reported.
// - Shift 3 to 18, normalize 4 to 19 cycles.
// - Last result read ends the calculation.
// - Error detection armed by byte 0, disarmed by final read.
// - Write during execution flags error, aborts calculation.
// - Armed operand byte read during execution flags error only; control reads do not.
// - Error flag cleared only by reading control.
// - Overflow on divide by zero, big product, normalized input.
// - Other operations clear overflow; software cannot write it.
module arcop_top import arcop_pkg::*; (
	input  wire logic           i_clk,
	input  wire logic           i_sys_rst,
	input  wire arcop_sfr_req_t i_sfr_req,
	output logic [7:0]          o_sfr_rdata,
	output logic                o_busy
);

	typedef struct packed {
		logic [5:0][7:0] ops;
		logic            err;
		logic            ovf;
		logic            slr;
		logic [4:0]      sc;
		arcop_phase_t    phase;
		arcop_op_t       op;
		logic            armed;
		logic            saw_hi;
		arcop_op_t       mid;
		logic [4:0]      cnt;
		logic            busy;
		logic [7:0]      rdata;
	} arcop_state_t;

	arcop_state_t   s;
	arcop_state_t   next_s;
	arcop_alu_res_t res;
	logic           hit;
	logic [2:0]     idx;
	logic           err_set;
	logic           final_idx;

	// Only the seven documented addresses answer; the rest are ignored
	assign hit = (i_sfr_req.addr >= ARCOP_ADDR_BYTE0) && (i_sfr_req.addr <= ARCOP_ADDR_CTRL);
	assign idx = 3'(i_sfr_req.addr - ARCOP_ADDR_BYTE0);

	// Division ends on byte 5, every other operation on byte 3
	assign final_idx = ((s.op == ARCOP_OP_DIV32) || (s.op == ARCOP_OP_DIV16)) ?
		(idx == ARCOP_IDX_BYTE5) : (idx == ARCOP_IDX_BYTE3);

	// Operands stay still during execution, so the result is formed from them directly
	arcop_alu u_alu (
		.i_operands (s.ops),
		.i_op       (s.op),
		.i_slr      (s.slr),
		.i_sc       (s.sc),
		.o_res      (res)
	);

	// Next state: execution progress first, then reads, then writes, which may abort
	always_comb begin
		next_s  = s;
		err_set = 1'b0;

		// Runs beside the core; commit in the last cycle of the fixed time
		if (s.phase == ARCOP_PH_EXEC) begin
			next_s.cnt = s.cnt + 5'h01;
			if (s.cnt == res.cycles - 5'h01) begin
				next_s.phase = ARCOP_PH_RESULT;
				next_s.ovf   = res.ovf;
				if (s.op == ARCOP_OP_DIV16) begin
					next_s.ops[1:0] = res.value[15:0];
					next_s.ops[5:4] = res.value[47:32];
				end else begin
					next_s.ops = res.value;
				end
				if (s.op == ARCOP_OP_NORM) begin
					next_s.sc = res.count;
				end
			end
		end

		// Reads: control read shows the flags and then clears the error flag
		if (i_sfr_req.rd && hit) begin
			if (idx == ARCOP_IDX_CTRL) begin
				next_s.rdata = {s.err, s.ovf, s.slr, s.sc};
				next_s.err   = 1'b0;
			end else begin
				next_s.rdata = s.ops[idx];
				if (s.phase == ARCOP_PH_EXEC && s.armed) begin
					err_set = 1'b1;
				end
				if (s.phase == ARCOP_PH_RESULT && final_idx) begin
					next_s.phase = ARCOP_PH_IDLE;
					next_s.armed = 1'b0;
				end
			end
		end else if (i_sfr_req.rd) begin
			next_s.rdata = 8'h00;
		end

		// Writes: any write while executing flags an error and drops the result
		if (i_sfr_req.wr && hit) begin
			if (s.phase == ARCOP_PH_EXEC) begin
				err_set      = 1'b1;
				next_s.phase = ARCOP_PH_IDLE;
				next_s.ops   = s.ops;
				next_s.ovf   = s.ovf;
				next_s.sc    = s.sc;
			end
			if (idx == ARCOP_IDX_CTRL) begin
				// Flag bits are hardware owned; only direction and count store
				next_s.slr = i_sfr_req.wdata[ARCOP_DIR_BIT];
				next_s.sc  = i_sfr_req.wdata[4:0];
				if (s.phase == ARCOP_PH_LOAD && s.saw_hi) begin
					next_s.phase = ARCOP_PH_EXEC;
					next_s.cnt   = 5'h00;
					next_s.op    = (i_sfr_req.wdata[4:0] == 5'h00) ?
						ARCOP_OP_NORM : ARCOP_OP_SHIFT;
				end
			end else begin
				next_s.ops[idx] = i_sfr_req.wdata;
				case (idx)
					ARCOP_IDX_BYTE0: begin
						next_s.phase  = ARCOP_PH_LOAD;
						next_s.armed  = 1'b1;
						next_s.saw_hi = 1'b0;
						next_s.mid    = ARCOP_OP_NONE;
					end
					ARCOP_IDX_BYTE1: begin
						next_s.mid = ARCOP_OP_MUL;
					end
					ARCOP_IDX_BYTE2,
					ARCOP_IDX_BYTE3: begin
						next_s.saw_hi = 1'b1;
					end
					ARCOP_IDX_BYTE4: begin
						next_s.mid = ARCOP_OP_DIV16;
					end
					ARCOP_IDX_BYTE5: begin
						// The later of bytes 1 and 4 tells multiply from short divide
						if (s.phase == ARCOP_PH_LOAD && (s.saw_hi || s.mid != ARCOP_OP_NONE)) begin
							next_s.phase = ARCOP_PH_EXEC;
							next_s.cnt   = 5'h00;
							next_s.op    = s.saw_hi ? ARCOP_OP_DIV32 : s.mid;
						end
					end
					default: begin
						next_s.saw_hi = s.saw_hi;
					end
				endcase
			end
		end

		// A new error beats a clearing read in the same cycle
		if (err_set) begin
			next_s.err = 1'b1;
		end
		next_s.busy = (next_s.phase == ARCOP_PH_EXEC);
	end

	// Single state register; operand bytes reset to zero for a defined start
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s        <= '0;
			s.ops    <= {6{ARCOP_BYTE_RESET}};
			s.err    <= ARCOP_CTRL_RESET[ARCOP_ERR_BIT];
			s.ovf    <= ARCOP_CTRL_RESET[ARCOP_OVF_BIT];
			s.slr    <= ARCOP_CTRL_RESET[ARCOP_DIR_BIT];
			s.sc     <= ARCOP_CTRL_RESET[4:0];
			s.phase  <= ARCOP_PH_IDLE;
			s.op     <= ARCOP_OP_NONE;
			s.mid    <= ARCOP_OP_NONE;
			s.rdata  <= 8'h00;
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state register
	assign o_sfr_rdata = s.rdata;
	assign o_busy      = s.busy;

	// Reference values that only the checks below read
	logic [31:0] mul_ref;
	logic [31:0] shift_ref;
	logic        wr_hit;
	assign mul_ref   = s.ops[1:0] * s.ops[5:4];
	assign shift_ref = s.slr ? (s.ops[3:0] >> s.sc) : (s.ops[3:0] << s.sc);
	assign wr_hit    = i_sfr_req.wr && hit;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	AST_DIV32_START: assert property (
		(s.phase == ARCOP_PH_LOAD) && s.saw_hi && wr_hit && (idx == ARCOP_IDX_BYTE5)
		|=> s.busy && (s.op == ARCOP_OP_DIV32) && (s.cnt == 5'h00))
		else $error("32/16 division did not start");

	AST_DIV32_TIME: assert property (
		s.busy && (s.op == ARCOP_OP_DIV32) && (s.cnt == 5'h10) && !wr_hit
		|=> (s.phase == ARCOP_PH_RESULT) && !s.busy)
		else $error("32/16 division did not end after 17 cycles");

	AST_BUSY_BOUND: assert property (
		s.busy |-> (s.cnt < 5'h13))
		else $error("execution ran past 19 cycles");

	AST_MUL_RESULT: assert property (
		s.busy && (s.op == ARCOP_OP_MUL) && (s.cnt == 5'h0A) && !wr_hit
		|=> (s.ops[3:0] == $past(mul_ref)) && (s.ovf == ($past(mul_ref) > ARCOP_MUL_LIMIT)))
		else $error("product or overflow wrong");

	AST_SHIFT_RESULT: assert property (
		s.busy && (s.op == ARCOP_OP_SHIFT) && (s.cnt == res.cycles - 5'h01) && !wr_hit
		|=> (s.ops[3:0] == $past(shift_ref)) && !s.ovf)
		else $error("shifted value wrong");

	AST_NORM_RESULT: assert property (
		s.busy && (s.op == ARCOP_OP_NORM) && (s.cnt == res.cycles - 5'h01) && !wr_hit
		&& (s.ops[3:0] != 32'h00000000)
		|=> s.ops[3][7] && (s.ovf == $past(s.ops[3][7]))
		&& (s.ops[3:0] == ($past(s.ops[3:0]) << s.sc)))
		else $error("normalize did not set the top bit");

	AST_ERR_ON_WRITE: assert property (
		s.busy && wr_hit |=> s.err && !s.busy)
		else $error("write during execution not flagged");

	AST_ERR_ON_READ: assert property (
		s.busy && s.armed && i_sfr_req.rd && hit && (idx != ARCOP_IDX_CTRL) && !wr_hit
		&& (s.cnt != res.cycles - 5'h01)
		|=> s.err && s.busy)
		else $error("armed read during execution mishandled");

	AST_ERR_CLEAR: assert property (
		i_sfr_req.rd && hit && (idx == ARCOP_IDX_CTRL) && !s.busy && !wr_hit
		|=> !s.err ##1 (!s.err || $past(s.busy)))
		else $error("error flag not cleared by control read");

	AST_ERR_STICKY: assert property (
		s.err && !(i_sfr_req.rd && hit && (idx == ARCOP_IDX_CTRL)) |=> s.err)
		else $error("error flag cleared without control read");

	AST_OVF_HW_ONLY: assert property (
		$changed(s.ovf) |-> $past(s.busy))
		else $error("overflow changed outside completion");

	AST_END_READ: assert property (
		(s.phase == ARCOP_PH_RESULT) && i_sfr_req.rd && hit && final_idx && !wr_hit
		|=> (s.phase == ARCOP_PH_IDLE) && !s.armed)
		else $error("final read did not end the calculation");

	// Completion times of the fixed-length operations
	AST_DIV16_TIME: assert property (
		s.busy && (s.op == ARCOP_OP_DIV16) && (s.cnt == 5'h08) && !wr_hit
		|=> (s.phase == ARCOP_PH_RESULT) && !s.busy)
		else $error("16/16 division did not end after 9 cycles");

	AST_MUL_TIME: assert property (
		s.busy && (s.op == ARCOP_OP_MUL) && (s.cnt == 5'h0A) && !wr_hit
		|=> (s.phase == ARCOP_PH_RESULT) && !s.busy)
		else $error("multiplication did not end after 11 cycles");

	// The longest shift stays busy through count 17 and ends right after it
	AST_SHIFT_TIME: assert property (
		s.busy && (s.op == ARCOP_OP_SHIFT) && (s.sc == 5'h1F) && !wr_hit
		|=> (s.busy == ($past(s.cnt) != 5'h11)))
		else $error("longest shift did not take 18 cycles");

	// Quotient times divisor plus remainder must give back the dividend
	AST_DIV16_RESULT: assert property (
		s.busy && (s.op == ARCOP_OP_DIV16) && (s.cnt == 5'h08) && !wr_hit
		&& (s.ops[5:4] != 16'h0000)
		|=> (32'(s.ops[1:0]) * 32'($past(s.ops[5:4])) + 32'(s.ops[5:4])
		== 32'($past(s.ops[1:0]))) && (s.ops[5:4] < $past(s.ops[5:4]))
		&& (s.ops[3:2] == $past(s.ops[3:2])) && !s.ovf)
		else $error("16/16 quotient or remainder wrong");

	AST_DIV32_RESULT: assert property (
		s.busy && (s.op == ARCOP_OP_DIV32) && (s.cnt == 5'h10) && !wr_hit
		&& (s.ops[5:4] != 16'h0000)
		|=> (48'(s.ops[3:0]) * 48'($past(s.ops[5:4])) + 48'(s.ops[5:4])
		== 48'($past(s.ops[3:0]))) && (s.ops[5:4] < $past(s.ops[5:4])) && !s.ovf)
		else $error("32/16 quotient or remainder wrong");

	// A zero divisor must always end with the overflow flag up
	AST_DIV0_OVF: assert property (
		s.busy && ((s.op == ARCOP_OP_DIV16) || (s.op == ARCOP_OP_DIV32)) && !wr_hit
		&& (s.cnt == res.cycles - 5'h01) && (s.ops[5:4] == 16'h0000)
		|=> s.ovf && (s.phase == ARCOP_PH_RESULT))
		else $error("division by zero did not raise overflow");

	// Start decoding: the write order picks the operation
	AST_ARM_ON_BYTE0: assert property (
		wr_hit && (idx == ARCOP_IDX_BYTE0) |=> s.armed && (s.phase == ARCOP_PH_LOAD))
		else $error("byte 0 write did not open a sequence");

	// Without bytes 2 or 3 the later of bytes 1 and 4 decides
	AST_SHORT_START: assert property (
		(s.phase == ARCOP_PH_LOAD) && !s.saw_hi && (s.mid != ARCOP_OP_NONE) && wr_hit
		&& (idx == ARCOP_IDX_BYTE5)
		|=> s.busy && (s.op == $past(s.mid)) && (s.cnt == 5'h00))
		else $error("16-bit operation did not start");

	AST_SHIFT_START: assert property (
		(s.phase == ARCOP_PH_LOAD) && s.saw_hi && wr_hit && (idx == ARCOP_IDX_CTRL)
		|=> s.busy && (s.cnt == 5'h00) && (s.op == (($past(i_sfr_req.wdata[4:0]) == 5'h00) ?
		ARCOP_OP_NORM : ARCOP_OP_SHIFT)))
		else $error("shift or normalize did not start");

	// A stray final write only stores data; it must never launch a calculation
	AST_NO_START: assert property (
		wr_hit && ((idx == ARCOP_IDX_CTRL) || (idx == ARCOP_IDX_BYTE5))
		&& ((s.phase != ARCOP_PH_LOAD)
		|| (!s.saw_hi && ((idx == ARCOP_IDX_CTRL) || (s.mid == ARCOP_OP_NONE))))
		|=> !s.busy)
		else $error("operation started without a complete load");

	AST_START_BY_WRITE: assert property (
		$rose(s.busy) |-> $past(wr_hit) && ($past(s.phase) == ARCOP_PH_LOAD))
		else $error("execution began without a final write");

	// Results stand until the final read or a new write
	AST_RESULT_HOLD: assert property (
		(s.phase == ARCOP_PH_RESULT) && !wr_hit && !(i_sfr_req.rd && hit && final_idx)
		|=> (s.phase == ARCOP_PH_RESULT) && $stable(s.ops))
		else $error("result changed before the final read");

	COV_DIV32_DONE: cover property (
		s.busy && (s.op == ARCOP_OP_DIV32) ##1 (s.phase == ARCOP_PH_RESULT));
	COV_MUL_DONE: cover property (
		s.busy && (s.op == ARCOP_OP_MUL) ##1 (s.phase == ARCOP_PH_RESULT));
	COV_NORM_DONE: cover property (
		s.busy && (s.op == ARCOP_OP_NORM) ##1 (s.phase == ARCOP_PH_RESULT));
	COV_ABORT: cover property (s.busy && wr_hit);
	// Shift completion, the fifth main scenario
	COV_SHIFT_DONE: cover property (
		s.busy && (s.op == ARCOP_OP_SHIFT) ##1 (s.phase == ARCOP_PH_RESULT));

endmodule : arcop_top

//--- verification/arcop_core_model.sv
// Core side of the register bus: one access at a time, in program order
module arcop_core_model import arcop_pkg::*; (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	output arcop_sfr_req_t  o_req
);
	timeunit 1ns;
	timeprecision 1ps;

	// Bus idle at time zero
	initial o_req = '0;

	// Write strobe for one cycle; released fields flip so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge i_clk);
		o_req.wr = 1'b0;
		o_req.addr = ~a;
		o_req.wdata = ~d;
	endtask : wr

	// Read strobe for one cycle; data is registered, so it is taken a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~o_req.wdata};
		@(negedge i_clk);
		o_req.rd = 1'b0;
		o_req.addr = ~a;
		d = i_rdata;
	endtask : rd
endmodule : arcop_core_model

//--- verification/tb.sv
module tb import arcop_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;

	logic           i_clk;
	logic           i_sys_rst;
	arcop_sfr_req_t sfr_req;
	logic [7:0]     sfr_rdata;
	logic           busy;
	int             err_total;
	int             n_tests;
	int             busy_n;
	logic [7:0]     r8;

	arcop_top arcop_top_inst (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_sfr_req   (sfr_req),
		.o_sfr_rdata (sfr_rdata),
		.o_busy      (busy)
	);

	arcop_core_model arcop_core_model_inst (
		.i_clk   (i_clk),
		.i_rdata (sfr_rdata),
		.o_req   (sfr_req)
	);

	// 50 MHz clock
	initial i_clk = 1'b0;
	always #10 i_clk = ~i_clk;

	// Busy cycles counted at the settled falling edge
	always @(negedge i_clk) begin
		if (busy === 1'b1) busy_n++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	// Writes n bytes; ix holds register indices and dt the data, first write lowest
	task automatic load(input logic [27:0] ix, input logic [55:0] dt, input int n);
		busy_n = 0;
		for (int k = 0; k < n; k++) begin
			arcop_core_model_inst.wr(ARCOP_ADDR_BYTE0 + {4'h0, ix[4*k+:4]}, dt[8*k+:8]);
		end
	endtask : load

	// Bounded wait for completion, then the busy length is compared
	task automatic finish(input logic [4:0] cyc);
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 40) begin
			@(negedge i_clk);
			k++;
		end
		if (k == 40) begin
			err_total++;
			summarize();
		end else begin
			chk(32'(busy_n), {27'h0, cyc});
		end
	endtask : finish

	task automatic rdc(input logic [2:0] i, input logic [7:0] exp);
		logic [7:0] d;
		arcop_core_model_inst.rd(ARCOP_ADDR_BYTE0 + {5'h00, i}, d);
		chk({24'h0, d}, {24'h0, exp});
	endtask : rdc

	// Byte 3 is read last, which closes a product or shift result
	task automatic rd32(input logic [31:0] exp);
		logic [31:0] v;
		for (int k = 0; k < 4; k++) begin
			arcop_core_model_inst.rd(ARCOP_ADDR_BYTE0 + 8'(k), v[8*k+:8]);
		end
		chk(v, exp);
	endtask : rd32

	task automatic done(input string s);
		$display("test %s done, errors so far %0d", s, err_total);
	endtask : done

	initial begin
		i_sys_rst = 1'b1;
		err_total = 0;
		n_tests = 0;
		busy_n = 0;
		repeat (5) @(negedge i_clk);
		i_sys_rst = 1'b0;
		// Reset values and an unmapped address
		rdc(3'h6, ARCOP_CTRL_RESET);
		rdc(3'h0, ARCOP_BYTE_RESET);
		arcop_core_model_inst.rd(8'hE8, r8);
		chk({24'h0, r8}, 32'h00000000);
		done("reset");
		// Multiply 3 x 5, order b0 b4 b1 b5
		load(28'h5140, 56'h00000503, 4);
		finish(ARCOP_CYC_MUL);
		rd32(32'h0000000F);
		rdc(3'h6, 8'h00);
		// Product above 16 bits; flags cannot be written by software
		load(28'h5140, 56'h01010000, 4);
		finish(ARCOP_CYC_MUL);
		rd32(32'h00010000);
		rdc(3'h6, 8'h40);
		arcop_core_model_inst.wr(ARCOP_ADDR_CTRL, 8'h80);
		rdc(3'h6, 8'h40);
		done("mul");
		// 16/16 division 1000 / 7, upper quotient bytes kept
		load(28'h5410, 56'h000703E8, 4);
		finish(ARCOP_CYC_DIV16);
		rd32(32'h0001008E);
		rdc(3'h4, 8'h06);
		rdc(3'h5, 8'h00);
		rdc(3'h6, 8'h00);
		// 32/16 division
		load(28'h543210, 56'h001012345678, 6);
		finish(ARCOP_CYC_DIV32);
		rd32(32'h01234567);
		rdc(3'h4, 8'h08);
		rdc(3'h5, 8'h00);
		// Division by zero
		load(28'h5410, 56'h00000005, 4);
		finish(ARCOP_CYC_DIV16);
		rdc(3'h4, 8'h05);
		rdc(3'h5, 8'h00);
		rdc(3'h6, 8'h40);
		done("div");
		// Shift right by 4, then left by the largest count
		load(28'h63210, 56'h2480000001, 5);
		finish(ARCOP_CYC_SHIFT_BASE + 5'h01);
		rd32(32'h08000000);
		rdc(3'h6, 8'h24);
		load(28'h63210, 56'h1F00000001, 5);
		finish(ARCOP_CYC_SHIFT_BASE + 5'h0F);
		rd32(32'h80000000);
		// Normalize, fifteen shifts, then an input already normalized
		load(28'h63210, 56'h0000010000, 5);
		finish(ARCOP_CYC_NORM_BASE + 5'h07);
		rd32(32'h80000000);
		rdc(3'h6, 8'h0F);
		load(28'h63210, 56'h0080000000, 5);
		finish(ARCOP_CYC_NORM_BASE);
		rd32(32'h80000000);
		rdc(3'h6, 8'h40);
		done("shift");
		// Read while busy: flag set, calculation runs to the end
		load(28'h5140, 56'h00000503, 4);
		arcop_core_model_inst.rd(ARCOP_ADDR_BYTE0, r8);
		finish(ARCOP_CYC_MUL);
		rd32(32'h0000000F);
		rdc(3'h6, 8'h80);
		rdc(3'h6, 8'h00);
		// Write while busy aborts the calculation
		load(28'h5140, 56'h00000503, 4);
		arcop_core_model_inst.wr(ARCOP_ADDR_BYTE1, 8'h00);
		@(negedge i_clk);
		chk({31'h0, busy}, 32'h00000000);
		rdc(3'h6, 8'h80);
		rdc(3'h6, 8'h00);
		done("error");
		summarize();
	end
endmodule : tb
